// >>> verilog/genset_load_step_and_mains_override.sv
/*
 * Five-step load add/subtract sequencer with start and wait timers, plus the mains
 * status override: remote start, disable auto start, delayed mains simulation,
 * flashing relay, priority master selection and limit set selection.
 * Assumes all pins and configuration are synchronous to ref_clk_in and that an engine
 * sequencer downstream consumes mains_ok_out to run waiting and cooldown cycles.
 */
module genset_load_step_and_mains_override
	import genset_ctrl_pkg::*;
#(
	parameter int NUM_DIN = 16,
	parameter int SEL_W = 4,
	parameter int POWER_W = 16,
	parameter int DELAY_W = 16,
	parameter int MS_CYCLES = MS_TICK_CYCLES
)
(
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	input wire logic [NUM_DIN-1:0] din_in,
	input wire logic [NUM_FUNC*SEL_W-1:0] func_sel_in,
	input wire logic [NUM_FUNC-1:0] func_defined_in,
	input wire logic [NUM_FUNC-1:0] func_nc_in,
	input wire logic [NUM_FUNC-1:0] func_neg_in,
	input wire logic [NUM_FUNC*2-1:0] input_alarm_code_a_in,
	input wire logic [POWER_W-1:0] active_power_in,
	input wire logic [POWER_W-1:0] add_power_level_in,
	input wire logic [POWER_W-1:0] subtract_power_level_in,
	input wire logic [DELAY_W-1:0] add_start_delay_in,
	input wire logic [DELAY_W-1:0] add_wait_delay_in,
	input wire logic [DELAY_W-1:0] subtract_start_delay_in,
	input wire logic [DELAY_W-1:0] subtract_wait_delay_in,
	input wire logic [HOURS_W-1:0] flash_on_hours_in,
	input wire logic [HOURS_W-1:0] flash_off_hours_in,
	input wire logic delayed_simulate_in,
	input wire logic mains_measured_ok_in,
	input wire logic genset_running_in,
	input wire logic genset_on_load_in,
	output logic [NUM_STEPS-1:0] load_add_out,
	output logic [NUM_STEPS-1:0] load_subtract_out,
	output logic [STEP_CNT_W-1:0] steps_supplied_out,
	output logic mains_ok_out,
	output logic mains_led_out,
	output logic force_start_out,
	output logic flash_relay_out,
	output logic master_out,
	output logic [1:0] limit_set_out,
	output logic [NUM_FUNC-1:0] input_alarm_out
);

	// ****************************************************************
	// Function inputs
	// ****************************************************************
	logic [NUM_FUNC-1:0] func_active;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_FUNC; gi++)
		begin : g_func
			input_function_map #(
				.NUM_DIN(NUM_DIN),
				.SEL_W(SEL_W)
			) u_map (
				.ref_clk_in(ref_clk_in),
				.sys_rst_in(sys_rst_in),
				.din_in(din_in),
				.sel_in(func_sel_in[gi*SEL_W +: SEL_W]),
				.defined_in(func_defined_in[gi]),
				.nc_in(func_nc_in[gi]),
				.neg_in(func_neg_in[gi]),
				.alarm_code_in(input_alarm_code_a_in[gi*2 +: 2]),
				.active_out(func_active[gi]),
				.alarm_out(input_alarm_out[gi])
			);
		end
	endgenerate

	logic remote_act;
	logic das_act;
	logic sim_act;
	assign remote_act = func_active[F_REMOTE];
	assign das_act = func_active[F_DISABLE_AUTO];
	assign sim_act = func_active[F_SIMULATE];

	// ****************************************************************
	// Millisecond and second enables
	// ****************************************************************
	localparam int MS_CNT_W = $clog2(MS_CYCLES + 1);
	localparam logic [MS_CNT_W-1:0] MS_LAST = MS_CNT_W'(MS_CYCLES - 1);
	localparam logic [9:0] SEC_LAST = 10'(MS_PER_S - 1);

	logic [MS_CNT_W-1:0] ms_cnt_q;
	logic [9:0] sec_cnt_q;
	logic ms_tick;
	logic sec_tick;

	assign ms_tick = (ms_cnt_q == MS_LAST);
	assign sec_tick = ms_tick && (sec_cnt_q == SEC_LAST);

	always_ff @(posedge ref_clk_in)
	begin
		if (sys_rst_in)
		begin
			ms_cnt_q <= '0;
			sec_cnt_q <= '0;
		end
		else
		begin
			ms_cnt_q <= ms_tick ? '0 : ms_cnt_q + 1'b1;
			if (ms_tick)
				sec_cnt_q <= (sec_cnt_q == SEC_LAST) ? '0 : sec_cnt_q + 1'b1;
		end
	end

	// ****************************************************************
	// Load step sequencer
	// ****************************************************************
	localparam logic [8:0] PULSE_LAST = 9'(PULSE_MS - 1);
	localparam logic [DELAY_W-1:0] DELAY_MAX = '1;

	logic [STEP_CNT_W-1:0] steps_q;
	logic [DELAY_W-1:0] add_low_ms_q;
	logic [DELAY_W-1:0] add_since_ms_q;
	logic [DELAY_W-1:0] sub_high_ms_q;
	logic [DELAY_W-1:0] sub_since_ms_q;
	logic [8:0] pulse_ms_q;
	logic pulse_busy_q;
	logic power_low;
	logic power_high;
	logic add_fire;
	logic sub_fire;

	assign power_low = active_power_in < add_power_level_in;
	assign power_high = active_power_in > subtract_power_level_in;

	// A new pulse waits for the previous one to end so two contactors never move together.
	assign add_fire = power_low && (add_low_ms_q >= add_start_delay_in)
		&& (add_since_ms_q >= add_wait_delay_in)
		&& (steps_q < STEP_CNT_W'(NUM_STEPS)) && !pulse_busy_q;
	assign sub_fire = !add_fire && power_high
		&& (sub_high_ms_q >= subtract_start_delay_in)
		&& (sub_since_ms_q >= subtract_wait_delay_in)
		&& (steps_q != '0) && !pulse_busy_q;

	always_ff @(posedge ref_clk_in)
	begin
		if (sys_rst_in)
		begin
			add_low_ms_q <= '0;
			sub_high_ms_q <= '0;
		end
		else
		begin
			// The start timers restart after each pulse, so every step needs a fresh delay.
			if (!power_low || add_fire)
				add_low_ms_q <= '0;
			else if (ms_tick && add_low_ms_q != DELAY_MAX)
				add_low_ms_q <= add_low_ms_q + 1'b1;
			if (!power_high || sub_fire)
				sub_high_ms_q <= '0;
			else if (ms_tick && sub_high_ms_q != DELAY_MAX)
				sub_high_ms_q <= sub_high_ms_q + 1'b1;
		end
	end

	// The wait timers start saturated so the first pulse after reset needs only the start delay.
	always_ff @(posedge ref_clk_in)
	begin
		if (sys_rst_in)
		begin
			add_since_ms_q <= DELAY_MAX;
			sub_since_ms_q <= DELAY_MAX;
		end
		else
		begin
			if (add_fire)
				add_since_ms_q <= '0;
			else if (ms_tick && add_since_ms_q != DELAY_MAX)
				add_since_ms_q <= add_since_ms_q + 1'b1;
			if (sub_fire)
				sub_since_ms_q <= '0;
			else if (ms_tick && sub_since_ms_q != DELAY_MAX)
				sub_since_ms_q <= sub_since_ms_q + 1'b1;
		end
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (sys_rst_in)
		begin
			steps_q <= '0;
			load_add_out <= '0;
			load_subtract_out <= '0;
			pulse_busy_q <= 1'b0;
			pulse_ms_q <= '0;
		end
		else if (add_fire)
		begin
			load_add_out <= NUM_STEPS'(1) << steps_q;
			steps_q <= steps_q + 1'b1;
			pulse_busy_q <= 1'b1;
			pulse_ms_q <= '0;
		end
		else if (sub_fire)
		begin
			load_subtract_out <= NUM_STEPS'(1) << (steps_q - 1'b1);
			steps_q <= steps_q - 1'b1;
			pulse_busy_q <= 1'b1;
			pulse_ms_q <= '0;
		end
		else if (pulse_busy_q && ms_tick)
		begin
			if (pulse_ms_q == PULSE_LAST)
			begin
				load_add_out <= '0;
				load_subtract_out <= '0;
				pulse_busy_q <= 1'b0;
			end
			else
				pulse_ms_q <= pulse_ms_q + 1'b1;
		end
	end

	assign steps_supplied_out = steps_q;

	// ****************************************************************
	// Flashing relay
	// ****************************************************************
	function automatic logic [FLASH_CNT_W-1:0] flash_period_s(input logic [HOURS_W-1:0] hours);
		logic [FLASH_CNT_W-1:0] p;
		p = FLASH_CNT_W'(hours) * FLASH_CNT_W'(S_PER_HOUR);
		if (hours == '0)
			p = FLASH_CNT_W'(FLASH_ZERO_S);
		return p;
	endfunction

	logic [FLASH_CNT_W-1:0] flash_s_q;
	logic [FLASH_CNT_W-1:0] flash_limit;
	logic [FLASH_CNT_W-1:0] flash_on_s;

	assign flash_on_s = flash_period_s(flash_on_hours_in);
	assign flash_limit = flash_relay_out ? flash_on_s : flash_period_s(flash_off_hours_in);

	always_ff @(posedge ref_clk_in)
	begin
		if (sys_rst_in)
		begin
			flash_s_q <= '0;
			flash_relay_out <= 1'b0;
		end
		else if (sec_tick)
		begin
			if (flash_s_q + 1'b1 >= flash_limit)
			begin
				flash_s_q <= '0;
				flash_relay_out <= ~flash_relay_out;
			end
			else
				flash_s_q <= flash_s_q + 1'b1;
		end
	end

	// ****************************************************************
	// Delayed simulation hold
	// ****************************************************************
	logic sim_prev_q;
	logic [FLASH_CNT_W-1:0] sim_hold_s_q;
	logic sim_hold_start;
	assign sim_hold_start = sim_act && !sim_prev_q && genset_running_in && genset_on_load_in;

	// Holding only on an on-load assertion lets the batteries charge before the stop sequence.
	always_ff @(posedge ref_clk_in)
	begin
		if (sys_rst_in)
		begin
			sim_prev_q <= 1'b0;
			sim_hold_s_q <= '0;
		end
		else
		begin
			sim_prev_q <= sim_act;
			if (!sim_act)
				sim_hold_s_q <= '0;
			else if (sim_hold_start)
				sim_hold_s_q <= flash_on_s;
			else if (sec_tick && sim_hold_s_q != '0)
				sim_hold_s_q <= sim_hold_s_q - 1'b1;
		end
	end

	// ****************************************************************
	// Mains decision and indicators
	// ****************************************************************
	logic mains_ok_d;
	logic mains_led_d;

	always_comb
	begin
		mains_ok_d = mains_measured_ok_in;
		mains_led_d = mains_measured_ok_in;
		if (func_defined_in[F_REMOTE])
		begin
			// Remote start is checked first, ahead of every other override.
			mains_ok_d = !remote_act;
			mains_led_d = !remote_act;
		end
		else if (das_act)
		begin
			// A running genset sees healthy mains and the engine sequencer winds it down.
			mains_ok_d = 1'b1;
			mains_led_d = 1'b1;
		end
		else if (sim_act)
		begin
			mains_led_d = 1'b1;
			if (!delayed_simulate_in || (sim_hold_s_q == '0 && !sim_hold_start))
				mains_ok_d = 1'b1;
		end
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (sys_rst_in)
		begin
			mains_ok_out <= 1'b1;
			mains_led_out <= 1'b1;
			force_start_out <= 1'b0;
		end
		else
		begin
			mains_ok_out <= mains_ok_d;
			mains_led_out <= mains_led_d;
			force_start_out <= func_active[F_FORCE_START] && !func_defined_in[F_REMOTE];
		end
	end

	// ****************************************************************
	// Priority master selection
	// ****************************************************************
	always_ff @(posedge ref_clk_in)
	begin
		if (sys_rst_in)
			master_out <= 1'b1;
		else if (!func_defined_in[F_PRIORITY])
			master_out <= 1'b1;
		else if (!func_active[F_PRIORITY])
			master_out <= 1'b0;
		else if (mains_ok_out && !mains_ok_d)
			master_out <= 1'b1;
	end

	// ****************************************************************
	// Limit set selection
	// ****************************************************************
	always_ff @(posedge ref_clk_in)
	begin
		if (sys_rst_in)
			limit_set_out <= LIMIT_SET_1;
		else if (func_active[F_SET3])
			limit_set_out <= LIMIT_SET_3;
		else if (func_active[F_SET2])
			limit_set_out <= LIMIT_SET_2;
		else
			limit_set_out <= LIMIT_SET_1;
	end

endmodule

// >>> verilog/genset_ctrl_pkg.sv
/*
 * Shared constants for the genset load-step sequencer and the mains override logic:
 * the function input indices, timing figures, limit set codes and alarm codes.
 * Assumes a single 50 MHz timebase. Every slower rate is made by dividers in the top module.
 */
// How it works
// - Five prioritized steps, add upward, remove downward.
// - Low power for add delay adds one step.
// - Add wait delay separates successive add pulses.
// - High power for subtract delay removes one.
// - Subtract wait delay separates successive subtract pulses.
// - Every add or subtract pulse lasts 0.25 s.
// - Mappable inputs, NO/NC, polarity, code 3 silences.
// - Remote start replaces mains sensing: present means failed.
// - Mains indicators follow remote start while used.
// - Disable auto start forces mains healthy.
// - Running genset still gets waiting and cooldown.
// - Disable or simulate signal shows mains present.
// - Passive disable or simulate input resumes normal mains sensing.
// - Remote start beats disable and force start.
// - Delayed simulation: off-load active input means healthy.
// - On-load assertion blocks simulation for flash on-time.
// - Remote start wins over delayed simulation mode.
// - Flashing relay toggles at each on/off period.
// - Zero hour flash period becomes two minutes.
// - Priority input makes master after each failure.
// - Three limit sets, inputs select second, third.
package genset_ctrl_pkg;

	// ****************************************************************
	// Timebase
	// ****************************************************************
	localparam int CLK_HZ = 50_000_000;
	localparam int MS_PER_S = 1000;
	localparam int MS_TICK_CYCLES = CLK_HZ / MS_PER_S;
	localparam int PULSE_MS = 250;
	localparam int S_PER_MIN = 60;
	localparam int S_PER_HOUR = 3600;
	localparam int FLASH_ZERO_MIN = 2;
	localparam int FLASH_ZERO_S = FLASH_ZERO_MIN * S_PER_MIN;

	// ****************************************************************
	// Load steps
	// ****************************************************************
	localparam int NUM_STEPS = 5;
	localparam int STEP_CNT_W = 3;

	// ****************************************************************
	// Function inputs
	// ****************************************************************
	localparam int NUM_FUNC = 7;
	localparam int F_REMOTE = 0;
	localparam int F_DISABLE_AUTO = 1;
	localparam int F_SIMULATE = 2;
	localparam int F_PRIORITY = 3;
	localparam int F_SET2 = 4;
	localparam int F_SET3 = 5;
	localparam int F_FORCE_START = 6;
	localparam logic [1:0] ALARM_CODE_SILENT = 2'h3;

	// ****************************************************************
	// Limit set selection codes
	// ****************************************************************
	localparam logic [1:0] LIMIT_SET_1 = 2'h0;
	localparam logic [1:0] LIMIT_SET_2 = 2'h1;
	localparam logic [1:0] LIMIT_SET_3 = 2'h2;

	localparam int FLASH_CNT_W = 24;
	localparam int HOURS_W = 8;

endpackage

// >>> verilog/input_function_map.sv
/*
 * One configurable function input: picks a digital input, applies contact sense and
 * switching polarity, and raises an alarm unless the alarm code silences it.
 * Assumes the pins are already synchronous to the clock.
 */
module input_function_map
	import genset_ctrl_pkg::*;
#(
	parameter int NUM_DIN = 16,
	parameter int SEL_W = 4
)
(
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	input wire logic [NUM_DIN-1:0] din_in,
	input wire logic [SEL_W-1:0] sel_in,
	input wire logic defined_in,
	input wire logic nc_in,
	input wire logic neg_in,
	input wire logic [1:0] alarm_code_in,
	output logic active_out,
	output logic alarm_out
);

	logic pin_level;
	logic contact_closed;
	logic active_d;

	always_comb
	begin
		pin_level = 1'b0;
		if (int'(sel_in) < NUM_DIN)
		begin
			pin_level = din_in[sel_in];
		end
		// A contact switched to negative pulls its pin low when closed.
		contact_closed = neg_in ? ~pin_level : pin_level;
		active_d = defined_in & (nc_in ? ~contact_closed : contact_closed);
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (sys_rst_in)
		begin
			active_out <= 1'b0;
			alarm_out <= 1'b0;
		end
		else
		begin
			active_out <= active_d;
			alarm_out <= active_d & (alarm_code_in != ALARM_CODE_SILENT);
		end
	end

endmodule

// >>> test/load_bank_model.sv
/*
 * Behavioural bank of five load contactors driven by the step pulses, and the power they draw.
 * Assumes the pulses are synchronous to clk_in and that the bench supplies the base power.
 */
module load_bank_model
	import genset_ctrl_pkg::*;
#(
	parameter int STEP_POWER = 100
)
(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [NUM_STEPS-1:0] add_in,
	input wire logic [NUM_STEPS-1:0] subtract_in,
	input wire logic [15:0] base_power_in,
	output logic [NUM_STEPS-1:0] bank_out,
	output logic [15:0] power_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// A contactor latches on the pulse itself, so a pulse on the wrong bit leaves a visible hole.
	always_ff @(posedge clk_in)
		if (rst_in)
			bank_out <= '0;
		else
			bank_out <= (bank_out | add_in) & ~subtract_in;

	assign power_out = base_power_in + 16'(STEP_POWER * $countones(bank_out));
endmodule

// >>> test/genset_load_step_and_mains_override_monitor.sv
/*
 * Port checker for the load step sequencer and the mains override logic.
 * Assumes it is bound to the top module and handed the same parameter values.
 */
module genset_load_step_and_mains_override_monitor
	import genset_ctrl_pkg::*;
#(
	parameter int NUM_DIN = 16,
	parameter int SEL_W = 4,
	parameter int MS_CYCLES = MS_TICK_CYCLES
)
(
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	input wire logic [NUM_DIN-1:0] din_in,
	input wire logic [NUM_FUNC*SEL_W-1:0] func_sel_in,
	input wire logic [NUM_FUNC-1:0] func_defined_in,
	input wire logic [NUM_FUNC-1:0] func_nc_in,
	input wire logic [NUM_FUNC-1:0] func_neg_in,
	input wire logic [NUM_FUNC*2-1:0] input_alarm_code_a_in,
	input wire logic [NUM_STEPS-1:0] load_add_out,
	input wire logic [NUM_STEPS-1:0] load_subtract_out,
	input wire logic [STEP_CNT_W-1:0] steps_supplied_out,
	input wire logic mains_ok_out,
	input wire logic mains_led_out,
	input wire logic master_out,
	input wire logic [1:0] limit_set_out,
	input wire logic [NUM_FUNC-1:0] input_alarm_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************************************
	// Helpers
	// ****************************************************************
	// Function levels are rebuilt from the pins so the mains checks never trust the design.
	logic [1:0] rst_hist_q;
	logic [NUM_FUNC-1:0] act;
	logic [NUM_FUNC-1:0] alm;
	logic settled;
	int idx;
	int pulse_q;

	always_ff @(posedge ref_clk_in)
		rst_hist_q <= {rst_hist_q[0], sys_rst_in};

	assign settled = (rst_hist_q == 2'h0);

	always_comb
	begin
		idx = 0;
		for (int f = 0; f < NUM_FUNC; f++)
		begin
			idx = int'(func_sel_in[f*SEL_W+:SEL_W]);
			act[f] = func_defined_in[f] & ((idx < NUM_DIN ? din_in[idx] : 1'b0)
				^ func_nc_in[f] ^ func_neg_in[f]);
			alm[f] = act[f] & (input_alarm_code_a_in[f*2+:2] != ALARM_CODE_SILENT);
		end
	end

	always_ff @(posedge ref_clk_in)
		if (sys_rst_in || ({load_add_out, load_subtract_out} == '0))
			pulse_q <= 0;
		else
			pulse_q <= pulse_q + 1;

	// ****************************************************************
	// Properties
	// ****************************************************************
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (sys_rst_in);

	a_add_step: assert property (
		$rose(|load_add_out) |-> steps_supplied_out == $past(steps_supplied_out) + 3'h1
			&& load_add_out == (5'h01 << $past(steps_supplied_out)))
		else $error("add pulse on wrong step");
	a_sub_step: assert property (
		$rose(|load_subtract_out) |-> steps_supplied_out == $past(steps_supplied_out) - 3'h1
			&& load_subtract_out == (5'h01 << steps_supplied_out))
		else $error("subtract pulse on wrong step");
	a_one_pulse: assert property ($onehot0({load_add_out, load_subtract_out}))
		else $error("more than one step pulse");
	a_step_cap: assert property (steps_supplied_out <= 3'h5)
		else $error("step count beyond five");
	a_pulse_max: assert property (pulse_q <= 251 * MS_CYCLES)
		else $error("step pulse too long");
	a_pulse_min: assert property (
		pulse_q != 0 && {load_add_out, load_subtract_out} == '0 |-> pulse_q >= 249 * MS_CYCLES)
		else $error("step pulse too short");
	a_remote_mains: assert property (
		settled && $past(func_defined_in[F_REMOTE], 2) && $past(func_defined_in[F_REMOTE])
			|-> mains_ok_out == !$past(act[F_REMOTE], 2) && mains_led_out == mains_ok_out)
		else $error("mains decision ignores remote start");
	a_das_mains: assert property (
		settled && !$past(func_defined_in[F_REMOTE], 2) && !$past(func_defined_in[F_REMOTE])
			&& $past(act[F_DISABLE_AUTO], 2) |-> mains_ok_out && mains_led_out)
		else $error("disable auto start not forcing mains healthy");
	a_limit_pick: assert property (
		settled |-> limit_set_out == ($past(act[F_SET3], 2) ? LIMIT_SET_3
			: ($past(act[F_SET2], 2) ? LIMIT_SET_2 : LIMIT_SET_1)))
		else $error("wrong limit set");
	a_alarm_code: assert property (settled |-> input_alarm_out == $past(alm))
		else $error("input alarm mismatch");
	a_master_free: assert property (
		settled && !$past(func_defined_in[F_PRIORITY], 2) && !$past(func_defined_in[F_PRIORITY])
			|-> master_out)
		else $error("not master without priority input");
endmodule

// >>> test/genset_load_step_and_mains_override_tb_top.sv
/*
 * Self-checking bench for the load step sequencer and the mains override logic.
 * Assumes the package, the design, the load bank model and the checker are compiled first.
 */
module genset_load_step_and_mains_override_tb_top
	import genset_ctrl_pkg::*;
	;
	timeunit 1ns;
	timeprecision 1ps;
	// The ms tick is cut to 10 cycles so that 250 ms pulses cost 2500 cycles.
	localparam int MS = 10;
	logic ref_clk_in, sys_rst_in, mains_measured_ok_in, delayed_simulate_in, gen_on;
	logic [15:0] din_in, active_power_in, add_power_level_in, subtract_power_level_in;
	logic [15:0] base, start_ms, wait_ms;
	logic [27:0] func_sel_in;
	logic [6:0] func_defined_in, func_nc_in, func_neg_in, input_alarm_out;
	logic [13:0] input_alarm_code_a_in;
	logic [7:0] flash_h;
	logic [4:0] load_add_out, load_subtract_out, bank;
	logic [2:0] steps_supplied_out;
	logic mains_ok_out, mains_led_out, force_start_out, flash_relay_out, master_out;
	logic [1:0] limit_set_out;
	int err_total = 0;
	int checks_done = 0;
	int cyc = 0;

	genset_load_step_and_mains_override #(.MS_CYCLES(MS)) uut (
		.ref_clk_in, .sys_rst_in, .din_in, .func_sel_in, .func_defined_in, .func_nc_in,
		.func_neg_in, .input_alarm_code_a_in, .active_power_in, .add_power_level_in,
		.subtract_power_level_in, .add_start_delay_in(start_ms), .add_wait_delay_in(wait_ms),
		.subtract_start_delay_in(start_ms), .subtract_wait_delay_in(wait_ms),
		.flash_on_hours_in(flash_h), .flash_off_hours_in(flash_h), .delayed_simulate_in,
		.mains_measured_ok_in, .genset_running_in(gen_on), .genset_on_load_in(gen_on),
		.load_add_out, .load_subtract_out, .steps_supplied_out, .mains_ok_out, .mains_led_out,
		.force_start_out, .flash_relay_out, .master_out, .limit_set_out, .input_alarm_out);

	load_bank_model bank_m (.clk_in(ref_clk_in), .rst_in(sys_rst_in), .add_in(load_add_out),
		.subtract_in(load_subtract_out), .base_power_in(base), .bank_out(bank),
		.power_out(active_power_in));

	initial
	begin
		ref_clk_in = 1'b0;
		forever #10 ref_clk_in = ~ref_clk_in;
	end

	always @(posedge ref_clk_in)
		cyc <= cyc + 1;

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			err_total++;
			$display("unexpected at %0t: saw %0h, wanted %0h", $time, seen, exp);
		end
	endtask

	task automatic test_done();
		if (err_total == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic wait_for(input bit up, input bit level, input int limit);
		int k;
		for (k = 0; k < limit && (up ? |load_add_out : |load_subtract_out) !== level; k++)
			@(negedge ref_clk_in);
		if (k == limit)
		begin
			err_total++;
			$display("unexpected at %0t: pulse wait ran out", $time);
			test_done();
		end
	endtask

	// First pulse after the start delay, then each one a wait delay after the one before.
	task automatic steps_run(input bit up, input int from, input int n);
		int t0;
		int lo;
		t0 = cyc;
		lo = 5;
		for (int k = 0; k < n; k++)
		begin
			wait_for(up, 1'b1, 4000);
			chk(cyc - t0 >= (lo - 1) * MS && cyc - t0 <= (lo + 3) * MS, 1);
			chk(up ? load_add_out : load_subtract_out, 32'h1 << (up ? from + k : from - 1 - k));
			chk(steps_supplied_out, up ? from + k + 1 : from - 1 - k);
			t0 = cyc;
			lo = 300;
			wait_for(up, 1'b0, 3000);
			chk(cyc - t0 >= 249 * MS, 1);
			chk(bank, (32'h1 << steps_supplied_out) - 1);
		end
	endtask

	task automatic quiet(input int n);
		repeat (n)
		begin
			@(negedge ref_clk_in);
			chk({load_add_out, load_subtract_out}, 0);
		end
	endtask

	task automatic mcase(input logic [6:0] d, input logic [6:0] p, input logic m, input logic s,
		input logic [2:0] e);
		func_defined_in = d;
		din_in[6:0] = p;
		mains_measured_ok_in = m;
		delayed_simulate_in = s;
		repeat (4) @(negedge ref_clk_in);
		chk({mains_ok_out, mains_led_out, force_start_out}, e);
	endtask

	initial
	begin
		sys_rst_in = 1'b1;
		din_in = '0;
		func_sel_in = 28'h6543210;
		func_defined_in = '0;
		func_nc_in = '0;
		func_neg_in = '0;
		input_alarm_code_a_in = '0;
		add_power_level_in = 16'h00FA;
		subtract_power_level_in = 16'h03E8;
		base = 16'h0200;
		start_ms = 16'h0005;
		wait_ms = 16'h012C;
		flash_h = 8'h00;
		mains_measured_ok_in = 1'b1;
		delayed_simulate_in = 1'b0;
		gen_on = 1'b0;
		repeat (4) @(negedge ref_clk_in);
		chk({steps_supplied_out, mains_ok_out, mains_led_out, force_start_out, flash_relay_out,
			master_out, limit_set_out, input_alarm_out, load_add_out, load_subtract_out},
			{3'h0, 1'h1, 1'h1, 1'h0, 1'h0, 1'h1, 2'h0, 7'h00, 10'h000});
		sys_rst_in = 1'b0;
		mcase(7'h00, 7'h00, 1'h0, 1'h0, 3'h0);
		mcase(7'h02, 7'h02, 1'h0, 1'h0, 3'h6);
		mcase(7'h02, 7'h00, 1'h0, 1'h0, 3'h0);
		mcase(7'h03, 7'h03, 1'h1, 1'h0, 3'h0);
		mcase(7'h01, 7'h00, 1'h0, 1'h0, 3'h6);
		mcase(7'h04, 7'h04, 1'h0, 1'h1, 3'h6);
		gen_on = 1'b1;
		mcase(7'h04, 7'h00, 1'h0, 1'h1, 3'h0);
		mcase(7'h04, 7'h04, 1'h0, 1'h1, 3'h2);
		gen_on = 1'b0;
		mcase(7'h05, 7'h05, 1'h1, 1'h1, 3'h0);
		mcase(7'h40, 7'h40, 1'h1, 1'h0, 3'h7);
		mcase(7'h41, 7'h40, 1'h1, 1'h0, 3'h6);
		func_nc_in[1] = 1'b1;
		mcase(7'h02, 7'h00, 1'h0, 1'h0, 3'h6);
		func_nc_in[1] = 1'b0;
		func_neg_in[1] = 1'b1;
		mcase(7'h02, 7'h00, 1'h0, 1'h0, 3'h6);
		chk(input_alarm_out[1], 1);
		func_neg_in[1] = 1'b0;
		mcase(7'h00, 7'h02, 1'h1, 1'h0, 3'h6);
		input_alarm_code_a_in[3:2] = ALARM_CODE_SILENT;
		mcase(7'h02, 7'h02, 1'h1, 1'h0, 3'h6);
		chk(input_alarm_out[1], 0);
		for (int i = 0; i < 4; i++)
		begin
			mcase(7'h30, {1'b0, i[1:0], 4'h0}, 1'h1, 1'h0, 3'h6);
			chk(limit_set_out, i[1] ? LIMIT_SET_3 : (i[0] ? LIMIT_SET_2 : LIMIT_SET_1));
		end
		mcase(7'h08, 7'h00, 1'h1, 1'h0, 3'h6);
		chk(master_out, 0);
		mcase(7'h08, 7'h08, 1'h1, 1'h0, 3'h6);
		chk(master_out, 0);
		mcase(7'h08, 7'h08, 1'h0, 1'h0, 3'h0);
		chk(master_out, 1);
		base = 16'h0000;
		steps_run(1'b1, 0, 3);
		quiet(4000);
		// Past one second here, so a zero period taken literally would already have toggled.
		chk(flash_relay_out, 0);
		add_power_level_in = 16'h0FFF;
		steps_run(1'b1, 3, 2);
		quiet(4000);
		add_power_level_in = 16'h00FA;
		base = 16'h0800;
		steps_run(1'b0, 5, 5);
		quiet(4000);
		test_done();
	end
endmodule

bind genset_load_step_and_mains_override genset_load_step_and_mains_override_monitor #(
	.NUM_DIN(NUM_DIN), .SEL_W(SEL_W), .MS_CYCLES(MS_CYCLES)) mon (.ref_clk_in, .sys_rst_in,
	.din_in, .func_sel_in, .func_defined_in, .func_nc_in, .func_neg_in, .input_alarm_code_a_in,
	.load_add_out, .load_subtract_out, .steps_supplied_out, .mains_ok_out, .mains_led_out,
	.master_out, .limit_set_out, .input_alarm_out);
